/* File: lan_scb_pkg.sv */
// shared constants and types for the control block interrupt logic
`default_nettype none

package lan_scb_pkg;

	// ------------------------------------------------------------
	// bus geometry
	// ------------------------------------------------------------
	localparam int unsigned DATA_W = 32;
	localparam int unsigned ADDR_W = 8;

	// ------------------------------------------------------------
	// register indices and byte addresses (byte address = 4 * index)
	// ------------------------------------------------------------
	localparam logic [5:0] STATUS_IDX = 6'h00;
	localparam logic [5:0] CMD_IDX = 6'h02;
	localparam logic [7:0] STATUS_ADDR = {STATUS_IDX, 2'h0};
	localparam logic [7:0] CMD_ADDR = {CMD_IDX, 2'h0};

	// ------------------------------------------------------------
	// command word layout and reset
	// ------------------------------------------------------------
	localparam logic [15:0] CMD_RESET = 16'h0000;
	localparam logic [15:0] CMD_STORE_MASK = 16'hFDFF;
	localparam int unsigned CMD_EXECUTED_BIT = 15;
	localparam int unsigned FRAME_RECEIVED_BIT = 14;
	localparam int unsigned CMD_INACTIVE_BIT = 13;
	localparam int unsigned RECEIVE_NOT_READY_BIT = 12;
	localparam int unsigned EARLY_RECEIVE_BIT = 11;
	localparam int unsigned FLOW_PAUSE_BIT = 10;
	localparam int unsigned SWI_BIT = 9;
	localparam int unsigned GIM_BIT = 8;

	// ------------------------------------------------------------
	// status word layout (pending causes share the mask layout)
	// ------------------------------------------------------------
	localparam int unsigned CAUSE_N = 7;
	localparam int unsigned CAUSE_LSB = 9;
	localparam int unsigned CMD_ST_LSB = 6;
	localparam int unsigned RX_ST_LSB = 2;
	localparam logic [6:0] PEND_RESET = 7'h00;

	// ------------------------------------------------------------
	// engine state encodings
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		RX_IDLE = 4'h0,
		RX_SUSPENDED = 4'h1,
		RX_SUSP_NO_DESC = 4'h9,
		RX_NO_RESOURCES = 4'h2,
		RX_NO_RES_NO_DESC = 4'hA,
		RX_READY = 4'h4,
		RX_READY_NO_DESC = 4'hC
	} rx_engine_state_t;

	typedef enum logic [1:0] {
		CMD_IDLE = 2'h0,
		CMD_SUSPENDED = 2'h1,
		CMD_LOW_QUEUE_ACTIVE = 2'h2,
		CMD_HIGH_QUEUE_ACTIVE = 2'h3
	} cmd_engine_state_t;

	// pending bank state
	typedef struct packed {
		logic [6:0] pend;
	} pend_state_t;

endpackage

`default_nettype wire

/* File: cause_pending_bank.sv */
// sticky pending bits for the interrupt causes, set wins over clear
`default_nettype none

module cause_pending_bank
(
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// set and clear strobes, one bit per cause
	input wire logic [6:0] set_in,
	input wire logic [6:0] clear_in,
	// pending causes
	output logic [6:0] pend_out
);

	lan_scb_pkg::pend_state_t state_q;
	lan_scb_pkg::pend_state_t state_d;

	// ------------------------------------------------------------
	// next state per bit
	// ------------------------------------------------------------
	// an event in the clearing cycle is kept
	always_comb
	begin
		state_d = state_q;
		for (int i = 0; i < 7; i++)
		begin
			if (set_in[i])
				state_d.pend[i] = 1'b1;
			else if (clear_in[i])
				state_d.pend[i] = 1'b0;
		end
	end

	// register the state
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			state_q <= '{pend: lan_scb_pkg::PEND_RESET};
		else
			state_q <= state_d;
	end

	assign pend_out = state_q.pend;

endmodule // cause_pending_bank

`default_nettype wire

/* File: lan_scb_interrupt_control.sv */
// control block command word, status word and interrupt line
`default_nettype none

module lan_scb_interrupt_control
(
	// clock and reset
	input wire logic clock_in,
	input wire logic rst_b_in,
	// apb slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// cause events from the engines, one-cycle pulses
	input wire logic cmd_executed_in,
	input wire logic frame_received_in,
	input wire logic cmd_engine_inactive_in,
	input wire logic receive_not_ready_in,
	input wire logic early_receive_in,
	input wire logic flow_pause_in,
	// engine states, same clock
	input wire logic [3:0] rx_engine_state_in,
	input wire logic [1:0] cmd_engine_state_in,
	// engine command byte to the engines
	output logic [7:0] engine_cmd_out,
	// interrupt
	output logic irq_out,
	output logic inta_b_out
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] cmd;
		logic [3:0] rx_st;
		logic [1:0] cmd_st;
		logic [31:0] rdata;
		logic irq;
	} state_t;

	state_t state_q;
	state_t state_d;

	logic [6:0] pend_w;
	logic [6:0] set_w;
	logic [6:0] clear_w;
	logic [6:0] cause_mask_w;
	logic setup_w;
	logic access_w;
	logic wr_cmd_w;
	logic wr_status_w;
	logic hit_any_w;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// address match against one register
	function automatic logic reg_hit(input logic [7:0] addr,
		input logic [7:0] target);
		reg_hit = (addr == target);
	endfunction

	// status word image
	function automatic logic [31:0] status_word(input logic [6:0] pend,
		input logic [1:0] cst, input logic [3:0] rst);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[lan_scb_pkg::CAUSE_LSB +: 7] = pend;
		w[lan_scb_pkg::CMD_ST_LSB +: 2] = cst;
		w[lan_scb_pkg::RX_ST_LSB +: 4] = rst;
		status_word = w;
	endfunction

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// zero wait states: every access ends in its first access cycle
	assign setup_w = psel_in & ~penable_in;
	assign access_w = psel_in & penable_in;
	assign hit_any_w = reg_hit(paddr_in, lan_scb_pkg::STATUS_ADDR) |
		reg_hit(paddr_in, lan_scb_pkg::CMD_ADDR);
	assign wr_cmd_w = access_w & pwrite_in &
		reg_hit(paddr_in, lan_scb_pkg::CMD_ADDR);
	assign wr_status_w = access_w & pwrite_in &
		reg_hit(paddr_in, lan_scb_pkg::STATUS_ADDR);
	assign pready_out = 1'b1;
	assign pslverr_out = access_w & ~hit_any_w;

	// ------------------------------------------------------------
	// pending causes
	// ------------------------------------------------------------
	// software request sets its cause
	assign set_w = {cmd_executed_in, frame_received_in,
		cmd_engine_inactive_in, receive_not_ready_in, early_receive_in,
		flow_pause_in, wr_cmd_w & pwdata_in[lan_scb_pkg::SWI_BIT]};
	// acknowledge by writing ones to the status word
	assign clear_w = wr_status_w ?
		pwdata_in[lan_scb_pkg::CAUSE_LSB +: 7] : 7'h00;

	cause_pending_bank u_pend
	(
		.clock_in(clock_in),
		.rst_b_in(rst_b_in),
		.set_in(set_w),
		.clear_in(clear_w),
		.pend_out(pend_w)
	);

	// per-cause masks, software request has none
	assign cause_mask_w = {state_q.cmd[lan_scb_pkg::CMD_EXECUTED_BIT],
		state_q.cmd[lan_scb_pkg::FRAME_RECEIVED_BIT],
		state_q.cmd[lan_scb_pkg::CMD_INACTIVE_BIT],
		state_q.cmd[lan_scb_pkg::RECEIVE_NOT_READY_BIT],
		state_q.cmd[lan_scb_pkg::EARLY_RECEIVE_BIT],
		state_q.cmd[lan_scb_pkg::FLOW_PAUSE_BIT], 1'b0};

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb
	begin
		state_d = state_q;
		state_d.rx_st = rx_engine_state_in;
		state_d.cmd_st = cmd_engine_state_in;
		// command word store, write-only bit dropped
		if (wr_cmd_w)
			state_d.cmd = pwdata_in[15:0] & lan_scb_pkg::CMD_STORE_MASK;
		// read data is fetched in the setup cycle
		if (setup_w & ~pwrite_in)
		begin
			if (reg_hit(paddr_in, lan_scb_pkg::STATUS_ADDR))
				// engine state fields in the status word
				state_d.rdata = status_word(pend_w, state_q.cmd_st,
					state_q.rx_st);
			else if (reg_hit(paddr_in, lan_scb_pkg::CMD_ADDR))
				state_d.rdata = {16'h0000, state_q.cmd};
			else
				state_d.rdata = 32'h0000_0000;
		end
		state_d.irq = (|(pend_w & ~cause_mask_w)) &
			~state_q.cmd[lan_scb_pkg::GIM_BIT];
	end

	// register the state
	always_ff @(posedge clock_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
			state_q <= '{cmd: lan_scb_pkg::CMD_RESET, rx_st: 4'h0,
				cmd_st: 2'h0, rdata: 32'h0000_0000, irq: 1'b0};
		else
			state_q <= state_d;
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata_out = state_q.rdata;
	assign engine_cmd_out = state_q.cmd[7:0];
	// line active low, from the registered request
	assign irq_out = state_q.irq;
	assign inta_b_out = ~state_q.irq;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!rst_b_in);

	AST_CMD_STORE: assert property (
		wr_cmd_w |=> (state_q.cmd ==
			($past(pwdata_in[15:0]) & lan_scb_pkg::CMD_STORE_MASK)))
		else $error("command word not stored");

	AST_CMD_RESET: assert property (
		$rose(rst_b_in) |->
			(state_q.cmd == lan_scb_pkg::CMD_RESET && !irq_out))
		else $error("command word not zero after reset");

	AST_CMD_READBACK: assert property (
		(setup_w && !pwrite_in && paddr_in == lan_scb_pkg::CMD_ADDR)
		|=> prdata_out == {16'h0000, $past(state_q.cmd)})
		else $error("command word readback wrong");

	AST_ENGINE_BYTE: assert property (
		wr_cmd_w |=> engine_cmd_out == $past(pwdata_in[7:0]))
		else $error("engine command byte not driven");

	AST_EXECUTED_MASKED: assert property (
		(pend_w == 7'h40 && state_q.cmd[15]) |=> !irq_out)
		else $error("masked executed cause reached the line");

	AST_FRAME_MASKED: assert property (
		(pend_w == 7'h20 && state_q.cmd[14]) |=> !irq_out)
		else $error("masked frame cause reached the line");

	AST_INACTIVE_MASKED: assert property (
		(pend_w == 7'h10 && state_q.cmd[13]) |=> !irq_out)
		else $error("masked inactive cause reached the line");

	AST_NOT_READY_MASKED: assert property (
		(pend_w == 7'h08 && state_q.cmd[12]) |=> !irq_out)
		else $error("masked not-ready cause reached the line");

	AST_EARLY_MASKED: assert property (
		(pend_w == 7'h04 && state_q.cmd[11]) |=> !irq_out)
		else $error("masked early cause reached the line");

	AST_PAUSE_MASKED: assert property (
		(pend_w == 7'h02 && state_q.cmd[10]) |=> !irq_out)
		else $error("masked pause cause reached the line");

	AST_SWI_ZERO: assert property (
		(wr_cmd_w && !pwdata_in[lan_scb_pkg::SWI_BIT] && !pend_w[0])
		|=> !pend_w[0])
		else $error("software interrupt raised by a zero");

	AST_SWI_RAISE: assert property (
		(wr_cmd_w && pwdata_in[9] && !pwdata_in[8])
		|=> pend_w[0] ##1 irq_out)
		else $error("software interrupt not raised");

	AST_GIM_BLOCKS: assert property (
		state_q.cmd[8] |=> (inta_b_out && !irq_out))
		else $error("line asserted under global mask");

	AST_GIM_OVERRIDE: assert property (
		(pend_w[0] && state_q.cmd[8]) |=> inta_b_out)
		else $error("global mask did not override request");

	AST_RX_FIELD: assert property (
		(setup_w && !pwrite_in && paddr_in == lan_scb_pkg::STATUS_ADDR)
		|=> prdata_out[5:2] == $past(state_q.rx_st))
		else $error("receive state field wrong");

	AST_STATUS_LOW: assert property (
		(setup_w && !pwrite_in && paddr_in == lan_scb_pkg::STATUS_ADDR)
		|=> prdata_out[1:0] == 2'h0)
		else $error("reserved status bits not zero");

	AST_RX_IDLE: assert property (
		(rx_engine_state_in == lan_scb_pkg::RX_IDLE) ##1
		(setup_w && !pwrite_in && paddr_in == lan_scb_pkg::STATUS_ADDR)
		|=> prdata_out[5:2] == 4'h0)
		else $error("idle receive state not reported");

	AST_CMD_FIELD: assert property (
		(setup_w && !pwrite_in && paddr_in == lan_scb_pkg::STATUS_ADDR)
		|=> prdata_out[7:6] == $past(state_q.cmd_st))
		else $error("command state field wrong");

	AST_LINE_ASSERT: assert property (
		((|(pend_w & cause_mask_w ^ pend_w)) && !state_q.cmd[8])
		|=> (irq_out && !inta_b_out))
		else $error("unmasked cause did not assert line");

	AST_CAUSE_PENDS: assert property (
		frame_received_in |=> pend_w[5])
		else $error("frame cause not recorded");

	AST_LINE_QUIET: assert property (
		!(|(pend_w & ~cause_mask_w)) |=> !irq_out)
		else $error("line asserted with nothing pending");

	AST_SWI_CLEAR: assert property (
		(wr_status_w && pwdata_in[lan_scb_pkg::SWI_BIT]) |=> !pend_w[0])
		else $error("software interrupt not cleared");

	AST_SWI_HOLDS: assert property (
		(pend_w[0] && !(wr_status_w && pwdata_in[9])) |=> pend_w[0])
		else $error("software interrupt dropped without clear");

endmodule // lan_scb_interrupt_control

`default_nettype wire

/* File: lan_scb_interrupt_control_test.sv */
// self-checking bench for the control block interrupt logic
`default_nettype none

module lan_scb_interrupt_control_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------
	// stimulus, observed outputs and bookkeeping
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [5:0] cause = 6'h00;
	logic [3:0] rx_st = 4'h0;
	logic [1:0] cmd_st = 2'h0;
	logic look = 1'b0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic inta_b;
	logic [7:0] eng_out;
	logic [7:0] eng = 8'h00;
	logic [32:0] exp_q[$];
	logic [3:0] rx_codes [7] = '{4'h0, 4'h1, 4'h9, 4'h2, 4'hA, 4'h4, 4'hC};
	int n_errors = 0;
	int comparisons = 0;

	// cause vector: bit 0 flow pause up to bit 5 command executed
	lan_scb_interrupt_control dut
	(
		.clock_in(clk), .rst_b_in(rst_b),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
		.pready_out(pready), .pslverr_out(pslverr),
		.cmd_executed_in(cause[5]), .frame_received_in(cause[4]),
		.cmd_engine_inactive_in(cause[3]),
		.receive_not_ready_in(cause[2]), .early_receive_in(cause[1]),
		.flow_pause_in(cause[0]), .rx_engine_state_in(rx_st),
		.cmd_engine_state_in(cmd_st), .engine_cmd_out(eng_out),
		.irq_out(irq), .inta_b_out(inta_b)
	);

	// free-running 250 MHz clock
	always #2 clk = ~clk;

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		comparisons++;
		if (seen !== want)
		begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen,
				want);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for pready
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// upper half of the word gets random filler, it must be ignored
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		apb(1'b1, a, {16'($urandom()), d});
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] want);
		exp_q.push_back(want);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic set_cmd(input logic [15:0] v);
		eng = v[7:0];
		wr(lan_scb_pkg::CMD_ADDR, v);
	endtask

	// note the expected interrupt pins and command byte, then probe
	task automatic look_at(input logic want);
		exp_q.push_back({23'h0, want, ~want, eng});
		@(posedge clk);
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
	endtask

	task automatic pulse(input int i);
		@(posedge clk);
		cause[i] <= 1'b1;
		@(posedge clk);
		cause[i] <= 1'b0;
	endtask

	task automatic report_and_stop;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// watcher: pairs each result with the oldest note
	// ------------------------------------------------------------
	always @(posedge clk)
	begin
		if (psel && penable && pready && !pwrite)
			check({pslverr, prdata}, exp_q.pop_front());
		else if (look)
			check({23'h0, irq, inta_b, eng_out}, exp_q.pop_front());
	end

	// watchdog well beyond the few hundred cycles the tests need
	initial
	begin
		repeat (20000) @(posedge clk);
		n_errors++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial
	begin
		void'($urandom(35));
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rd(lan_scb_pkg::CMD_ADDR, 33'h0);
		rd(lan_scb_pkg::STATUS_ADDR, 33'h0);
		look_at(1'b0);
		$display("test reset done");
		// all masks, global mask and software request at once
		set_cmd({8'hFF, 8'($urandom())});
		look_at(1'b0);
		rd(lan_scb_pkg::CMD_ADDR, {17'h0, 8'hFD, eng});
		wr(lan_scb_pkg::STATUS_ADDR, 16'h0200);
		set_cmd({8'h00, eng});
		look_at(1'b0);
		$display("test command word done");
		for (int i = 0; i < 6; i++)
		begin
			set_cmd(16'(1 << (10 + i)) | {8'h00, eng});
			pulse(i);
			look_at(1'b0);
			rd(lan_scb_pkg::STATUS_ADDR, 33'(1 << (10 + i)));
			set_cmd({8'h01, eng});
			look_at(1'b0);
			set_cmd({8'h00, eng});
			look_at(1'b1);
			wr(lan_scb_pkg::STATUS_ADDR, 16'(1 << (10 + i)));
			look_at(1'b0);
		end
		$display("test cause masks done");
		set_cmd({8'h02, eng});
		look_at(1'b1);
		repeat (5) @(posedge clk);
		look_at(1'b1);
		rd(lan_scb_pkg::CMD_ADDR, {17'h0, 8'h00, eng});
		set_cmd({8'h00, eng});
		look_at(1'b1);
		wr(lan_scb_pkg::STATUS_ADDR, 16'h0200);
		look_at(1'b0);
		$display("test software interrupt done");
		for (int k = 0; k < 28; k++)
		begin
			@(posedge clk);
			rx_st <= rx_codes[k % 7];
			cmd_st <= 2'(k / 7);
			repeat (2) @(posedge clk);
			rd(lan_scb_pkg::STATUS_ADDR,
				{25'h0, 2'(k / 7), rx_codes[k % 7], 2'h0});
		end
		$display("test engine states done");
		wr(8'h10, 16'hFFFF);
		rd(8'h10, {1'b1, 32'h0});
		rd(lan_scb_pkg::CMD_ADDR, {17'h0, 8'h00, eng});
		$display("test unmapped done");
		report_and_stop();
	end

endmodule // lan_scb_interrupt_control_test

`default_nettype wire
